// file: ulm_led_map.sv
// I2C register target with user LED control and system indicator mapping
//
// Summary of operation
// R1 - Three byte read/write mapping registers at 0x17, 0x18, 0x19 over I2C.
// R2 - A one bit copies its system indicator onto that user LED.
// R3 - Bits 0..7: power, cell low, charging, notice, cooler, switch, host supply, cable.
// R4 - Mapping never alters the system indicator outputs.
// R5 - Direct on/off still works; next mapped status update overwrites it.
// R6 - Several indicators may be mapped onto one user LED at once.
// R7 - Several mapped indicators light the user LED as a logical OR.
// R8 - Writing 0x01 or 0x00 to an LED control register turns it on or off.
// R9 - On cable power after boot, power indicator blinks 400 ms on, 400 ms off.
`default_nettype none
`include "ulm_defines.svh"

module ulm_led_map #(
  parameter int BLINK_CYCLES = `ULM_BLINK_CYCLES
) (
  input  wire logic            clock,
  input  wire logic            rst_n,
  input  wire logic            ce,
  input  wire logic            scl_i,
  input  wire logic            sda_i,
  output var  logic            sda_o,
  output var  logic            sda_oe,
  input  wire logic [7:0]      sys_ind,
  input  wire logic            cable_running,
  output var  logic [7:0]      ind_out,
  output var  ulm_pkg::ulm_led_s user_led
);
  import ulm_pkg::*;

  // ---------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] map_off(input int i);
    case (i)
      0:       map_off = `ULM_OFF_MAP_ORG;
      1:       map_off = `ULM_OFF_MAP_GRN;
      default: map_off = `ULM_OFF_MAP_BLU;
    endcase
  endfunction : map_off

  function automatic logic [7:0] ctrl_off(input int i);
    case (i)
      0:       ctrl_off = `ULM_OFF_CTRL_ORG;
      1:       ctrl_off = `ULM_OFF_CTRL_GRN;
      default: ctrl_off = `ULM_OFF_CTRL_BLU;
    endcase
  endfunction : ctrl_off

  function automatic logic mapped_level(input logic [7:0] sel, input logic [7:0] src);
    mapped_level = |(sel & src);
  endfunction : mapped_level

  // ---------------------------------------------------------------
  // Pin synchronisers and bus conditions
  // ---------------------------------------------------------------
  logic [2:0]     scl_ff;
  logic [2:0]     sda_ff;
  logic           scl_f;
  logic           sda_f;
  logic           scl_p;
  logic           sda_p;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_ff <= 3'h7;
      sda_ff <= 3'h7;
      scl_f  <= 1'b1;
      sda_f  <= 1'b1;
      scl_p  <= 1'b1;
      sda_p  <= 1'b1;
    end
    else if (ce)
    begin
      scl_ff <= {scl_ff[1:0], scl_i};
      sda_ff <= {sda_ff[1:0], sda_i};
      if (scl_ff[1] == scl_ff[2])
        scl_f <= scl_ff[2];
      if (sda_ff[1] == sda_ff[2])
        sda_f <= sda_ff[2];
      scl_p <= scl_f;
      sda_p <= sda_f;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  assign scl_rise  = ce && scl_f && !scl_p;
  assign scl_fall  = ce && !scl_f && scl_p;
  assign bus_start = ce && scl_f && scl_p && sda_p && !sda_f;
  assign bus_stop  = ce && scl_f && scl_p && !sda_p && sda_f;

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  ulm_i2c_state_e state;
  logic [2:0]     bit_cnt;
  logic [7:0]     shift_in;
  logic [7:0]     tx;
  logic [7:0]     ptr;
  logic           rd_mode;
  logic [7:0]     map_sel [3];
  logic [7:0]     eff_ind;
  logic           blink;
  logic [31:0]    blink_cnt;
  logic           wr_en;
  logic [7:0]     wr_data;
  logic           upd;
  logic [7:0]     rd_next;

  assign wr_data = {shift_in[6:0], sda_f};
  assign wr_en   = scl_rise && state == ST_WDATA && bit_cnt == 3'h7;

  function automatic logic [7:0] rd_byte(input logic [7:0] p);
    rd_byte = 8'h00;
    for (int i = 0; i < 3; i++)
    begin
      if (p == map_off(i))
        rd_byte = map_sel[i];
      if (p == ctrl_off(i))
        rd_byte = {7'h00, user_led[i]};
    end
  endfunction : rd_byte

  // Byte that the next read will shift out
  always_comb
  begin
    rd_next = rd_byte(ptr);
  end

  // ---------------------------------------------------------------
  // I2C target sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state    <= ST_IDLE;
      bit_cnt  <= 3'h0;
      shift_in <= 8'h00;
      tx       <= 8'h00;
      ptr      <= 8'h00;
      rd_mode  <= 1'b0;
      sda_oe   <= 1'b0;
      sda_o    <= 1'b0;
    end
    else if (bus_start)
    begin
      state   <= ST_ADDR;
      bit_cnt <= 3'h0;
      sda_oe  <= 1'b0;
    end
    else if (bus_stop)
    begin
      state  <= ST_IDLE;
      sda_oe <= 1'b0;
    end
    else if (scl_rise)
    begin
      case (state)
        ST_ADDR, ST_PTR, ST_WDATA:
        begin
          shift_in <= wr_data;
          bit_cnt  <= bit_cnt + 3'h1;
          if (bit_cnt == 3'h7)
          begin
            case (state)
              ST_ADDR:
              begin
                rd_mode <= sda_f;
                state   <= (shift_in[6:0] == `ULM_I2C_ADDR) ? ST_ADDR_ACK : ST_IDLE;
              end
              ST_PTR:
              begin
                ptr   <= wr_data;
                state <= ST_PTR_ACK;
              end
              default:
              begin
                ptr   <= ptr + 8'h01;
                state <= ST_WDATA_ACK;
              end
            endcase
          end
        end
        ST_RDATA:
        begin
          bit_cnt <= bit_cnt + 3'h1;
          if (bit_cnt == 3'h7)
            state <= ST_RD_ACK;
        end
        ST_RD_ACK:
          state <= sda_f ? ST_IDLE : ST_RD_NEXT;
        default:
          state <= state;
      endcase
    end
    else if (scl_fall)
    begin
      case (state)
        ST_ADDR_ACK, ST_PTR_ACK, ST_WDATA_ACK:
        begin
          if (!sda_oe)
            sda_oe <= 1'b1;
          else if (state == ST_ADDR_ACK && rd_mode)
          begin
            tx      <= rd_next;
            ptr     <= ptr + 8'h01;
            sda_oe  <= ~rd_next[7];
            bit_cnt <= 3'h0;
            state   <= ST_RDATA;
          end
          else
          begin
            sda_oe  <= 1'b0;
            bit_cnt <= 3'h0;
            state   <= (state == ST_ADDR_ACK) ? ST_PTR : ST_WDATA;
          end
        end
        ST_RDATA:
        begin
          tx     <= {tx[6:0], 1'b0};
          sda_oe <= ~tx[6];
        end
        ST_RD_ACK:
          sda_oe <= 1'b0;
        ST_RD_NEXT:
        begin
          tx      <= rd_next;
          ptr     <= ptr + 8'h01;
          sda_oe  <= ~rd_next[7];
          bit_cnt <= 3'h0;
          state   <= ST_RDATA;
        end
        default:
          state <= state;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Power indicator blink on cable supply
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      blink_cnt <= 32'h0;
      blink     <= 1'b0;
    end
    else if (ce)
    begin
      if (!cable_running)
      begin
        blink_cnt <= 32'h0;
        blink     <= 1'b1;
      end
      else if (blink_cnt == 32'(BLINK_CYCLES - 1))  // see R9
      begin
        blink_cnt <= 32'h0;
        blink     <= ~blink;
      end
      else
        blink_cnt <= blink_cnt + 32'h1;
    end
  end

  // Indicator vector, bit order per the mapping layout
  always_comb
  begin
    eff_ind = sys_ind;                                          // see R3
    if (cable_running)
      eff_ind[`ULM_BIT_POWER] = blink;                          // see R9
  end

  // System indicators pass through untouched by any mapping
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      ind_out <= 8'h00;
    else if (ce)
      ind_out <= eff_ind;                                       // see R4
  end

  assign upd = ce && (eff_ind != ind_out);

  // ---------------------------------------------------------------
  // Mapping registers and user LED state
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 3; i++)
        map_sel[i] <= `ULM_RST_MAP;
    end
    else
    begin
      for (int i = 0; i < 3; i++)
        if (wr_en && ptr == map_off(i))
          map_sel[i] <= wr_data;                                // see R1
    end
  end

  // A status update wins over a direct write in the same cycle on an LED whose mapping register is nonzero
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      user_led <= '{default: `ULM_RST_LED};
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (upd && map_sel[i] != 8'h00)
          user_led[i] <= mapped_level(map_sel[i], eff_ind);     // see R2 R5 R6 R7
        else if (wr_en && ptr == ctrl_off(i))
          user_led[i] <= (wr_data == `ULM_LED_ON);              // see R8
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_map_store;
    @(posedge clock) disable iff (!rst_n)
    (wr_en && ptr == `ULM_OFF_MAP_GRN) |=> map_sel[1] == $past(wr_data);
  endproperty
  a_map_store: assert property (p_map_store) else $error("map write lost"); // see R1

  property p_unmapped_hold;
    @(posedge clock) disable iff (!rst_n)
    (upd && map_sel[0] == 8'h00 && !(wr_en && ptr == `ULM_OFF_CTRL_ORG))
      |=> $stable(user_led.orange);
  endproperty
  a_unmapped_hold: assert property (p_unmapped_hold) else $error("unmapped led moved"); // see R2

  property p_cable_bit;
    @(posedge clock) disable iff (!rst_n)
    ce |=> ind_out[`ULM_BIT_CABLE] == $past(sys_ind[`ULM_BIT_CABLE]);
  endproperty
  a_cable_bit: assert property (p_cable_bit) else $error("bit order wrong"); // see R3

  property p_passthrough;
    @(posedge clock) disable iff (!rst_n)
    ce ##1 ce |-> ind_out == $past(eff_ind);
  endproperty
  a_passthrough: assert property (p_passthrough) else $error("indicator altered"); // see R4

  property p_overwrite;
    @(posedge clock) disable iff (!rst_n)
    (upd && map_sel[2] != 8'h00)
      |=> user_led.blue == $past(mapped_level(map_sel[2], eff_ind));
  endproperty
  a_overwrite: assert property (p_overwrite) else $error("update not applied"); // see R5

  property p_or_merge;
    @(posedge clock) disable iff (!rst_n)
    (upd && $countones(map_sel[0]) >= 2 && |(map_sel[0] & eff_ind)) |=> user_led.orange;
  endproperty
  a_or_merge: assert property (p_or_merge) else $error("or merge failed"); // see R6 R7

  property p_direct;
    @(posedge clock) disable iff (!rst_n)
    (wr_en && ptr == `ULM_OFF_CTRL_GRN && !(upd && map_sel[1] != 8'h00))
      |=> user_led.green == ($past(wr_data) == `ULM_LED_ON);
  endproperty
  a_direct: assert property (p_direct) else $error("direct command lost"); // see R8

  property p_blink;
    @(posedge clock) disable iff (!rst_n)
    (ce && cable_running && blink_cnt == 32'(BLINK_CYCLES - 1)) |=> blink != $past(blink);
  endproperty
  a_blink: assert property (p_blink) else $error("blink phase wrong"); // see R9

  property p_blink_bound;
    @(posedge clock) disable iff (!rst_n)
    blink_cnt < 32'(BLINK_CYCLES);
  endproperty
  a_blink_bound: assert property (p_blink_bound) else $error("blink count overrun"); // see R9

  c_map_write:  cover property (@(posedge clock) disable iff (!rst_n) wr_en && ptr == `ULM_OFF_MAP_ORG);
  c_read_byte:  cover property (@(posedge clock) disable iff (!rst_n) state == ST_RD_ACK);
  c_overwrite:  cover property (@(posedge clock) disable iff (!rst_n) upd && map_sel[0] != 8'h00);
  c_blink_flip: cover property (@(posedge clock) disable iff (!rst_n) cable_running && $changed(blink));

endmodule : ulm_led_map
`default_nettype wire

// file: ulm_defines.svh
// Register offsets, bus address, reset values and timing counts of the LED mapping block
`ifndef ULM_DEFINES_SVH
`define ULM_DEFINES_SVH

`define ULM_I2C_ADDR       7'h6b
`define ULM_OFF_CTRL_ORG   8'h09
`define ULM_OFF_CTRL_GRN   8'h0a
`define ULM_OFF_CTRL_BLU   8'h0b
`define ULM_OFF_MAP_ORG    8'h17
`define ULM_OFF_MAP_GRN    8'h18
`define ULM_OFF_MAP_BLU    8'h19
`define ULM_RST_MAP        8'h00
`define ULM_RST_LED        1'b0
`define ULM_LED_ON         8'h01
`define ULM_LED_OFF        8'h00
`define ULM_BIT_POWER      0
`define ULM_BIT_CABLE      7
`define ULM_CLK_HZ         20000000
`define ULM_BLINK_MS       400
`define ULM_BLINK_CYCLES   ((`ULM_BLINK_MS) * ((`ULM_CLK_HZ) / 1000))

`endif

// file: ulm_pkg.sv
// Types shared by the LED mapping block
`default_nettype none
package ulm_pkg;

  typedef struct packed {
    logic blue;
    logic green;
    logic orange;
  } ulm_led_s;

  typedef enum {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_PTR,
    ST_PTR_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RD_ACK,
    ST_RD_NEXT
  } ulm_i2c_state_e;

endpackage : ulm_pkg
`default_nettype wire

// file: ulm_i2c_host.sv
// I2C controller model standing in for the host processor
`default_nettype none
`include "ulm_defines.svh"
module ulm_i2c_host #(
  parameter int H = 10
) (
  input  wire logic clock,
  output var  logic scl,
  output var  logic sda_drv,
  input  wire logic sda_in
);
  timeunit 1ns;
  timeprecision 1ns;
  int nacks = 0;

  // Bus idles high between frames
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // --------------------------------
  // Bit and byte level
  // --------------------------------
  task automatic wt();
    repeat (H) @(negedge clock);
  endtask : wt

  // Data moves only while clock is low, held well past each fall
  task automatic bit_io(input logic b, output logic r);
    sda_drv = b;
    wt();
    scl = 1'b1;
    wt();
    r = sda_in;
    scl = 1'b0;
    wt();
  endtask : bit_io

  task automatic start();
    sda_drv = 1'b1;
    wt();
    scl = 1'b1;
    wt();
    sda_drv = 1'b0;
    wt();
    scl = 1'b0;
    wt();
  endtask : start

  task automatic stop();
    sda_drv = 1'b0;
    wt();
    scl = 1'b1;
    wt();
    sda_drv = 1'b1;
    wt();
  endtask : stop

  // Ninth bit is always released: target ack on writes, our nack on reads
  task automatic xfer(input logic [7:0] d, input logic rd, output logic [7:0] r);
    logic a;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r[i]);
    bit_io(1'b1, a);
    if (!rd && a)
      nacks++;
  endtask : xfer

  // --------------------------------
  // Register transfers
  // --------------------------------
  task automatic write_reg(input logic [7:0] ptr, input logic [7:0] d);
    logic [7:0] r;
    start();
    xfer({`ULM_I2C_ADDR, 1'b0}, 1'b0, r);
    xfer(ptr, 1'b0, r);
    xfer(d, 1'b0, r);
    stop();
  endtask : write_reg

  task automatic read_reg(input logic [7:0] ptr, output logic [7:0] d);
    logic [7:0] r;
    start();
    xfer({`ULM_I2C_ADDR, 1'b0}, 1'b0, r);
    xfer(ptr, 1'b0, r);
    start();
    xfer({`ULM_I2C_ADDR, 1'b1}, 1'b0, r);
    xfer(8'hff, 1'b1, d);
    stop();
  endtask : read_reg
endmodule : ulm_i2c_host
`default_nettype wire

// file: tb_user_led_mapping.sv
// Self-checking bench for the user LED mapping block
`default_nettype none
`include "ulm_defines.svh"
module tb_user_led_mapping;
  timeunit 1ns;
  timeprecision 1ns;
  import ulm_pkg::*;
  logic       clock = 1'b0;
  logic       rst_n = 1'b0;
  logic       ce = 1'b1;
  logic       cable_running = 1'b0;
  logic [7:0] sys_ind = 8'h00;
  logic       scl;
  logic       sda_drv;
  logic       sda_o;
  logic       sda_oe;
  logic [7:0] ind_out;
  ulm_led_s   user_led;
  int         bad_count = 0;
  int         comparisons = 0;
  wire logic  sda = sda_drv & (sda_oe ? sda_o : 1'b1);

  initial
    forever #25 clock = ~clock;

  ulm_led_map #(.BLINK_CYCLES(20)) ulm_led_map_inst (
    .clock(clock), .rst_n(rst_n), .ce(ce), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .sys_ind(sys_ind),
    .cable_running(cable_running), .ind_out(ind_out), .user_led(user_led));

  ulm_i2c_host ulm_i2c_host_inst (
    .clock(clock), .scl(scl), .sda_drv(sda_drv), .sda_in(sda));

  // --------------------------------
  // Helpers
  // --------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc

  task automatic drive(input logic [7:0] s);
    sys_ind = s;
    cyc(3);
  endtask : drive

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim();
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim

  // --------------------------------
  // Tests
  // --------------------------------
  task automatic test_reset();
    logic [7:0] r;
    for (int i = 0; i < 3; i++)
    begin
      ulm_i2c_host_inst.read_reg(`ULM_OFF_MAP_ORG + 8'(i), r);
      chk(r, `ULM_RST_MAP);
    end
    ulm_i2c_host_inst.read_reg(8'h20, r);
    chk(r, 8'h00);
    chk({5'h00, user_led}, 8'h00);
    $display("test_reset done");
  endtask : test_reset

  task automatic test_bits();
    logic [7:0] m;
    for (int i = 0; i < 8; i++)
    begin
      m = 8'h01 << i;
      sys_ind = 8'h00;
      ulm_i2c_host_inst.write_reg(`ULM_OFF_MAP_ORG, m);
      drive(m);
      chk({7'h00, user_led.orange}, 8'h01);
      chk(ind_out, m);
      drive(~m);
      chk({7'h00, user_led.orange}, 8'h00);
      chk(ind_out, ~m);
    end
    $display("test_bits done");
  endtask : test_bits

  task automatic test_multi();
    logic [7:0] r;
    ulm_i2c_host_inst.write_reg(`ULM_OFF_MAP_GRN, 8'h30);
    ulm_i2c_host_inst.read_reg(`ULM_OFF_MAP_GRN, r);
    chk(r, 8'h30);
    drive(8'h10);
    chk({7'h00, user_led.green}, 8'h01);
    drive(8'h20);
    chk({7'h00, user_led.green}, 8'h01);
    drive(8'hcf);
    chk({7'h00, user_led.green}, 8'h00);
    $display("test_multi done");
  endtask : test_multi

  task automatic test_direct();
    logic [7:0] r;
    drive(8'h00);
    ulm_i2c_host_inst.write_reg(`ULM_OFF_CTRL_BLU, `ULM_LED_ON);
    cyc(3);
    chk({7'h00, user_led.blue}, 8'h01);
    ulm_i2c_host_inst.read_reg(`ULM_OFF_CTRL_BLU, r);
    chk(r, 8'h01);
    ulm_i2c_host_inst.write_reg(`ULM_OFF_CTRL_BLU, `ULM_LED_OFF);
    cyc(3);
    chk({7'h00, user_led.blue}, 8'h00);
    ulm_i2c_host_inst.write_reg(`ULM_OFF_MAP_BLU, 8'h04);
    ulm_i2c_host_inst.write_reg(`ULM_OFF_CTRL_BLU, `ULM_LED_ON);
    cyc(3);
    chk({7'h00, user_led.blue}, 8'h01);
    drive(8'h02);
    chk({7'h00, user_led.blue}, 8'h00);
    $display("test_direct done");
  endtask : test_direct

  task automatic test_blink();
    logic v;
    drive(8'h00);
    ulm_i2c_host_inst.write_reg(`ULM_OFF_MAP_ORG, 8'h01);
    cable_running = 1'b1;
    v = ind_out[0];
    for (int i = 0; i < 60 && ind_out[0] === v; i++)
      @(negedge clock);
    v = ind_out[0];
    cyc(10);
    chk({6'h00, user_led.orange, ind_out[0]}, {6'h00, v, v});
    cyc(20);
    chk({6'h00, user_led.orange, ind_out[0]}, {6'h00, ~v, ~v});
    cable_running = 1'b0;
    $display("test_blink done");
  endtask : test_blink

  task automatic test_freeze();
    drive(8'h00);
    ce = 1'b0;
    sys_ind = 8'h5a;
    cyc(5);
    chk(ind_out, 8'h00);
    ce = 1'b1;
    cyc(3);
    chk(ind_out, 8'h5a);
    $display("test_freeze done");
  endtask : test_freeze

  initial
  begin
    cyc(8);
    rst_n = 1'b1;
    cyc(4);
    test_reset();
    test_bits();
    test_multi();
    test_direct();
    test_blink();
    test_freeze();
    chk(8'(ulm_i2c_host_inst.nacks), 8'h00);
    end_sim();
  end

  initial
  begin
    repeat (60000) @(posedge clock);
    bad_count++;
    end_sim();
  end
endmodule : tb_user_led_mapping
`default_nettype wire
